// File: rtl/eepc_ctrl.sv
// eeprom program and erase control with an avalon-mm register slave
`include "eepc_defs.svh"

// How it works
// - latch plus voltage in one write: neither
// - low-voltage inhibit status always reads zero
// - byte bit wins; else row or bulk
// - erase-mode bit selects erase versus program
// - latch bit routes array paths to latches
// - voltage bit switches high voltage on
// - protect bits reset set; clear first 64
// - setting protect bits allowed any time
// - special modes: protect register freely writable
// - bulk-protect refuses bulk and row erase
// - low-voltage protect enable is storage only
// - five region bits block their regions; bulk erase ignores them
// - clock select picks e clock or rc
// - array writes ignored while voltage on
// - writing zero ends cycle, reads resume
// - odd and even bits test mode only
// - array answers only when enabled
// - marked option bits write once early; freely in special modes
// - voltage needs latch, load, then voltage
// - latch clear: array reads like rom
module eepc_ctrl
  import eepc_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic [12:0] ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [3:0]  BYTEENABLE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  input  wire logic        TEST_MODE,
  input  wire logic        BOOT_MODE,
  input  wire logic        ARRAY_ENABLE,
  output logic             ARR_RD,
  output logic      [9:0]  ARR_ADDR,
  input  wire logic [7:0]  ARR_RDATA,
  output logic      [9:0]  ARR_PROG_ADDR,
  output logic      [7:0]  ARR_PROG_DATA,
  output logic             LATCH_MODE,
  output logic             ERASE_MODE,
  output logic             ERASE_BYTE,
  output logic             ERASE_ROW,
  output logic             HV_ON,
  output logic             PUMP_CLK_SEL
);

  eepc_state_s st;
  eepc_state_s nx;

  // all checks run on the system clock and pause during reset
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  // ==========================================
  // decode helpers
  logic [10:0] idx;
  logic        req;
  logic        fire;
  logic        special;
  logic        win_open;
  logic        in_array;
  logic [9:0]  arr_off;
  logic [7:0]  wd;
  logic        wr_lane;
  logic [10:0] arr_span;

  assign idx      = ADDRESS[12:2];
  assign req      = READ | WRITE;
  assign fire     = req && (st.ph_reg == 2'd2);
  assign special  = TEST_MODE | BOOT_MODE;
  assign win_open = st.win_cnt_reg < `EEPC_WINDOW_CYCLES;
  assign arr_span = idx - `EEPC_IDX_ARRAY_BASE;
  assign in_array = ARRAY_ENABLE && (idx >= `EEPC_IDX_ARRAY_BASE) &&
                    (arr_span < `EEPC_ARRAY_BYTES);
  assign arr_off  = arr_span[9:0];
  assign wd       = WRITEDATA[7:0];
  assign wr_lane  = WRITE && BYTEENABLE[0];

  // region number of an array offset
  function automatic logic [2:0] region_of(input logic [9:0] off);
    if (off < `EEPC_REG1_START) begin
      return 3'd0;
    end else if (off < `EEPC_REG2_START) begin
      return 3'd1;
    end else if (off < `EEPC_REG3_START) begin
      return 3'd2;
    end else if (off < `EEPC_REG4_START) begin
      return 3'd3;
    end
    return 3'd4;
  endfunction

  // true when the requested high-voltage operation must not reach the array
  function automatic logic refused(input logic [7:0] pc, input logic [7:0] bp,
                                   input logic [9:0] off);
    logic bulk_or_row;
    logic bulk;
    bulk_or_row = pc[`EEPC_PC_ERASE] && !pc[`EEPC_PC_BYTE];
    bulk        = bulk_or_row && !pc[`EEPC_PC_ROW];
    if (bulk_or_row && bp[`EEPC_BP_BULK]) begin
      return 1'b1;
    end
    if (bulk) begin
      return 1'b0;
    end
    return bp[region_of(off)];
  endfunction

  // ==========================================
  // next state
  always_comb begin
    nx = st;
    nx.arr_rd_reg = 1'b0;
    if (st.win_cnt_reg < `EEPC_WINDOW_CYCLES) begin
      nx.win_cnt_reg = st.win_cnt_reg + 7'h01;
    end

    // bus handshake: issue, capture, complete
    case (st.ph_reg)
      2'd0: begin
        if (req) begin
          nx.ph_reg = 2'd1;
          // rom-like reads only while the latch bit is clear
          if (READ && in_array && !st.pctl_reg[`EEPC_PC_LAT]) begin
            nx.arr_rd_reg   = 1'b1;
            nx.arr_addr_reg = arr_off;
          end
        end
      end
      2'd1: begin
        nx.ph_reg   = 2'd2;
        nx.wait_reg = 1'b0;
        nx.rdata_reg = 8'h00;
        if (READ) begin
          if (in_array) begin
            nx.rdata_reg = st.pctl_reg[`EEPC_PC_LAT] ? 8'h00 : ARR_RDATA;
          end else if (idx == `EEPC_IDX_PROG_CTL) begin
            nx.rdata_reg = st.pctl_reg & ~(8'h01 << `EEPC_PC_LOW_VOLTAGE_INHIBIT_STATUS);
          end else if (idx == `EEPC_IDX_BLOCK_PROT) begin
            nx.rdata_reg = st.eeprom_block_protect_reg;
          end else if (idx == `EEPC_IDX_OPTIONS) begin
            nx.rdata_reg = st.opt_reg;
          end
        end
      end
      2'd2: begin
        nx.ph_reg   = 2'd0;
        nx.wait_reg = 1'b1;
      end
      default: begin
        nx.ph_reg   = 2'd0;
        nx.wait_reg = 1'b1;
      end
    endcase

    // writes take effect at the edge that completes the transfer
    if (fire && wr_lane) begin
      if (in_array) begin
        // latched address and data frozen while voltage is on
        if (st.pctl_reg[`EEPC_PC_LAT] && !st.pctl_reg[`EEPC_PC_PGM]) begin
          nx.lat_addr_reg = arr_off;
          nx.lat_data_reg = wd;
          if (st.seq_reg == SEQ_LATCHED) begin
            nx.seq_reg = SEQ_LOADED;
          end
        end
      end else if (idx == `EEPC_IDX_PROG_CTL) begin
        if (wd == 8'h00) begin
          nx.pctl_reg = 8'h00;
          nx.seq_reg  = SEQ_IDLE;
        end else begin
          nx.pctl_reg[4:2] = wd[4:2];
          if (TEST_MODE) begin
            nx.pctl_reg[`EEPC_PC_ODD]  = wd[`EEPC_PC_ODD];
            nx.pctl_reg[`EEPC_PC_EVEN] = wd[`EEPC_PC_EVEN];
          end
          if (st.pctl_reg[`EEPC_PC_PGM]) begin
            // latch cannot move under high voltage
            nx.pctl_reg[`EEPC_PC_PGM] = wd[`EEPC_PC_PGM];
          end else if (wd[`EEPC_PC_LAT] && wd[`EEPC_PC_PGM] &&
                       !st.pctl_reg[`EEPC_PC_LAT]) begin
            nx.pctl_reg[`EEPC_PC_LAT] = 1'b0;
            nx.pctl_reg[`EEPC_PC_PGM] = 1'b0;
            nx.seq_reg                = SEQ_IDLE;
          end else begin
            nx.pctl_reg[`EEPC_PC_LAT] = wd[`EEPC_PC_LAT];
            nx.pctl_reg[`EEPC_PC_PGM] = wd[`EEPC_PC_PGM] && wd[`EEPC_PC_LAT] &&
                                        (st.seq_reg == SEQ_LOADED);
            if (!wd[`EEPC_PC_LAT]) begin
              nx.seq_reg = SEQ_IDLE;
            end else if (!wd[`EEPC_PC_PGM] && !st.pctl_reg[`EEPC_PC_LAT]) begin
              nx.seq_reg = SEQ_LATCHED;
            end
          end
        end
      end else if (idx == `EEPC_IDX_BLOCK_PROT) begin
        if (special || win_open) begin
          nx.eeprom_block_protect_reg = wd;
        end else begin
          nx.eeprom_block_protect_reg = st.eeprom_block_protect_reg | wd;
        end
      end else if (idx == `EEPC_IDX_OPTIONS) begin
        // unmarked bits always writable; marked ones once, early, or freely in special modes
        nx.opt_reg = (st.opt_reg & `EEPC_OPT_ONCE_MASK) | (wd & ~`EEPC_OPT_ONCE_MASK);
        if (special || (win_open && !st.opt_done_reg)) begin
          nx.opt_reg = wd;
          nx.opt_done_reg = !special;
        end
      end
    end

    // voltage follows the bit with no timeout of its own
    nx.hv_reg = nx.pctl_reg[`EEPC_PC_PGM] &&
                !refused(nx.pctl_reg, nx.eeprom_block_protect_reg, nx.lat_addr_reg);
  end

  // ==========================================
  // state register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st.wait_reg     <= 1'b1;
      st.ph_reg       <= 2'd0;
      st.rdata_reg    <= 8'h00;
      st.pctl_reg     <= 8'h00;
      st.eeprom_block_protect_reg    <= `EEPC_BP_RESET;
      st.opt_reg      <= `EEPC_OPT_RESET;
      st.opt_done_reg <= 1'b0;
      st.win_cnt_reg  <= 7'h00;
      st.seq_reg      <= SEQ_IDLE;
      st.lat_addr_reg <= 10'h000;
      st.lat_data_reg <= 8'h00;
      st.hv_reg       <= 1'b0;
      st.arr_rd_reg   <= 1'b0;
      st.arr_addr_reg <= 10'h000;
    end else begin
      st <= nx;
    end
  end

  // ==========================================
  // outputs, all straight from the state register
  assign READDATA      = {24'h000000, st.rdata_reg};
  assign WAITREQUEST   = st.wait_reg;
  assign ARR_RD        = st.arr_rd_reg;
  assign ARR_ADDR      = st.arr_addr_reg;
  assign ARR_PROG_ADDR = st.lat_addr_reg;
  assign ARR_PROG_DATA = st.lat_data_reg;
  assign LATCH_MODE    = st.pctl_reg[`EEPC_PC_LAT];
  assign ERASE_MODE    = st.pctl_reg[`EEPC_PC_ERASE];
  assign ERASE_BYTE    = st.pctl_reg[`EEPC_PC_BYTE];
  assign ERASE_ROW     = st.pctl_reg[`EEPC_PC_ROW];
  assign HV_ON         = st.hv_reg;
  assign PUMP_CLK_SEL  = st.opt_reg[`EEPC_OPT_PUMP_CLOCK_SELECT];

  // ==========================================
  // assertions
  logic wr_pctl;
  logic wr_eeprom_block_protect;
  logic wr_opt;
  assign wr_pctl  = fire && wr_lane && !in_array && (idx == `EEPC_IDX_PROG_CTL);
  assign wr_eeprom_block_protect = fire && wr_lane && !in_array && (idx == `EEPC_IDX_BLOCK_PROT);
  assign wr_opt   = fire && wr_lane && !in_array && (idx == `EEPC_IDX_OPTIONS);

  sequence s_latch_load;
    st.seq_reg == SEQ_LOADED;
  endsequence

  sequence s_hv_rise;
    $rose(HV_ON);
  endsequence

  sequence s_rom_issue;
    (st.ph_reg == 2'd0) && READ && in_array && !LATCH_MODE;
  endsequence

  both_bits_clear_a: assert property (
    (wr_pctl && wd[1:0] == 2'b11 && !st.pctl_reg[`EEPC_PC_LAT] &&
     !st.pctl_reg[`EEPC_PC_PGM]) |=> (!LATCH_MODE && !HV_ON))
    else $error("latch and voltage set by one write");

  low_voltage_inhibit_status_zero_a: assert property (
    (fire && READ && !in_array && idx == `EEPC_IDX_PROG_CTL) |-> !READDATA[`EEPC_PC_LOW_VOLTAGE_INHIBIT_STATUS])
    else $error("inhibit status read as one");

  hv_order_a: assert property (
    s_hv_rise |-> ($past(st.seq_reg) == SEQ_LOADED) && LATCH_MODE)
    else $error("voltage applied out of sequence");

  eeprom_block_protect_lock_a: assert property (
    (wr_eeprom_block_protect && !special && !win_open) |=>
      ((st.eeprom_block_protect_reg & $past(st.eeprom_block_protect_reg)) == $past(st.eeprom_block_protect_reg)))
    else $error("protect bit cleared after window");

  eeprom_block_protect_set_a: assert property (
    wr_eeprom_block_protect |=> ((st.eeprom_block_protect_reg & $past(wd)) == $past(wd)))
    else $error("protect bit not set by write");

  bulk_refuse_a: assert property (
    HV_ON |-> !(ERASE_MODE && !ERASE_BYTE && st.eeprom_block_protect_reg[`EEPC_BP_BULK]))
    else $error("bulk or row erase under bulk protect");

  region_guard_a: assert property (
    (HV_ON && !(ERASE_MODE && !ERASE_BYTE && !ERASE_ROW)) |->
      !st.eeprom_block_protect_reg[region_of(ARR_PROG_ADDR)])
    else $error("voltage on a protected region");

  array_freeze_a: assert property (
    (s_latch_load ##0 (HV_ON && fire && wr_lane && in_array)) |=>
      $stable(ARR_PROG_ADDR) && $stable(ARR_PROG_DATA))
    else $error("latched data changed under voltage");

  bus_answer_a: assert property (
    ($rose(req) && WAITREQUEST) |-> ##[2:2] !WAITREQUEST)
    else $error("bus answer late");

  rom_strobe_a: assert property (
    s_rom_issue |=> ARR_RD && (ARR_ADDR == $past(arr_off)))
    else $error("array read not issued");

  strobe_pulse_a: assert property (
    ARR_RD |=> !ARR_RD)
    else $error("array read strobe longer than one cycle");

  latch_read_zero_a: assert property (
    (fire && READ && in_array && LATCH_MODE) |-> (READDATA == 32'h00000000))
    else $error("array read while latch set");

  array_off_a: assert property (
    (!ARRAY_ENABLE && (st.ph_reg == 2'd0) && READ) |=> !ARR_RD)
    else $error("disabled array was read");

  zero_clear_a: assert property (
    (wr_pctl && (wd == 8'h00)) |=> ((st.pctl_reg == 8'h00) && !HV_ON))
    else $error("zero write left the cycle running");

  odd_even_lock_a: assert property (
    (wr_pctl && !TEST_MODE && (wd != 8'h00)) |=>
      ((st.pctl_reg & `EEPC_PC_TEST_MASK) == ($past(st.pctl_reg) & `EEPC_PC_TEST_MASK)))
    else $error("row program bits written outside test mode");

  // no internal timeout: software alone sets the pulse length
  hv_hold_a: assert property (
    (HV_ON && !(fire && wr_lane)) |=> HV_ON)
    else $error("voltage dropped without a write");

  hv_latch_a: assert property (
    HV_ON |-> (LATCH_MODE && st.pctl_reg[`EEPC_PC_PGM]))
    else $error("voltage on without its bits");

  window_clear_a: assert property (
    (wr_eeprom_block_protect && !special && win_open) |=> (st.eeprom_block_protect_reg == $past(wd)))
    else $error("protect write refused inside window");

  free_write_a: assert property (
    (wr_eeprom_block_protect && special) |=> (st.eeprom_block_protect_reg == $past(wd)))
    else $error("protect write refused in special mode");

  opt_once_a: assert property (
    (wr_opt && !special && (st.opt_done_reg || !win_open)) |=>
      ((st.opt_reg & `EEPC_OPT_ONCE_MASK) == ($past(st.opt_reg) & `EEPC_OPT_ONCE_MASK)))
    else $error("write-once option bits changed");

endmodule

// File: rtl/eepc_defs.svh
// register offsets, field positions, reset values and timing counts for the eeprom control block
`ifndef EEPC_DEFS_SVH
`define EEPC_DEFS_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define EEPC_IDX_OPTIONS      11'h039
`define EEPC_IDX_PROG_CTL     11'h03b
`define EEPC_IDX_BLOCK_PROT   11'h035
`define EEPC_IDX_ARRAY_BASE   11'h400
`define EEPC_ARRAY_BYTES      11'h280

// ==========================================
// program control fields
`define EEPC_PC_PGM           0
`define EEPC_PC_LAT           1
`define EEPC_PC_ERASE         2
`define EEPC_PC_ROW           3
`define EEPC_PC_BYTE          4
`define EEPC_PC_LOW_VOLTAGE_INHIBIT_STATUS          5
`define EEPC_PC_EVEN          6
`define EEPC_PC_ODD           7
`define EEPC_PC_TEST_MASK     8'hc0
`define EEPC_PC_USER_MASK     8'h1f

// ==========================================
// block protect fields
`define EEPC_BP_BULK          7
`define EEPC_BP_LOW_VOLTAGE_PROTECT_ENABLE         6
`define EEPC_BP_RESET         8'hff

// ==========================================
// options fields
`define EEPC_OPT_PUMP_CLOCK_SELECT         6
`define EEPC_OPT_RESET        8'h10
`define EEPC_OPT_ONCE_MASK    8'h37

// ==========================================
// array region bounds (first offset of each region above region 0)
`define EEPC_REG1_START       10'h020
`define EEPC_REG2_START       10'h060
`define EEPC_REG3_START       10'h0e0
`define EEPC_REG4_START       10'h200

// ==========================================
// timing
`define EEPC_WINDOW_CYCLES    7'h40

`endif

// File: rtl/eepc_pkg.sv
// types shared by the eeprom program and erase control block
package eepc_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LATCHED,
    SEQ_LOADED
  } eepc_seq_e;

  typedef struct packed {
    logic        wait_reg;
    logic [1:0]  ph_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  pctl_reg;
    logic [7:0]  eeprom_block_protect_reg;
    logic [7:0]  opt_reg;
    logic        opt_done_reg;
    logic [6:0]  win_cnt_reg;
    eepc_seq_e   seq_reg;
    logic [9:0]  lat_addr_reg;
    logic [7:0]  lat_data_reg;
    logic        hv_reg;
    logic        arr_rd_reg;
    logic [9:0]  arr_addr_reg;
  } eepc_state_s;
endpackage

// File: verification/test_eeprom_program_erase_control.sv
// self-checking testbench for the eeprom program and erase control block
`include "eepc_defs.svh"
module test_eeprom_program_erase_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic        clk_sys;
  logic        srst;
  logic [12:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        test_mode;
  logic        boot_mode;
  logic        array_enable;
  logic        arr_rd;
  logic [9:0]  arr_addr;
  logic [7:0]  arr_rdata;
  logic [9:0]  pa;
  logic [7:0]  pd;
  logic [4:0]  outs;
  logic        pump;
  int          mismatches;
  int          num_checks;
  int          rs[5] = '{0, 32, 96, 224, 512};
  int          rn[5] = '{32, 64, 128, 288, 128};
  logic [7:0]  ers[4] = '{8'h16, 8'h0e, 8'h06, 8'h1e};
  logic [9:0]  off;
  logic [7:0]  d;
  logic [7:0]  rd;

  // array model: offset-derived data, only while the read strobe is up
  assign arr_rdata = arr_rd ? (arr_addr[7:0] ^ 8'h5a) : 8'h00;

  eepc_ctrl eepc_ctrl_i (
    .CLK_SYS(clk_sys), .SRST(srst), .ADDRESS(address), .READ(read), .WRITE(write),
    .BYTEENABLE(4'h1), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .TEST_MODE(test_mode), .BOOT_MODE(boot_mode),
    .ARRAY_ENABLE(array_enable), .ARR_RD(arr_rd), .ARR_ADDR(arr_addr), .ARR_RDATA(arr_rdata),
    .ARR_PROG_ADDR(pa), .ARR_PROG_DATA(pd), .LATCH_MODE(outs[4]), .ERASE_MODE(outs[3]),
    .ERASE_BYTE(outs[2]), .ERASE_ROW(outs[1]), .HV_ON(outs[0]), .PUMP_CLK_SEL(pump)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================
  // reporting
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  // latch, erase, byte, row, high voltage; sampled a cycle after outputs settle
  task automatic cmp_out(input logic [4:0] exp);
    repeat (2) @(negedge clk_sys);
    num_checks++;
    if (outs !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t outputs %b expected %b", $time, outs, exp);
    end
    @(posedge clk_sys);
  endtask

  // ==========================================
  // avalon master: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [10:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    address   <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic rdchk(input logic [10:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp_reg({8'h0, rd}, {8'h0, exp});
  endtask

  task automatic load(input logic [7:0] ctl, input logic [9:0] o, input logic [7:0] v);
    bus(1'b1, `EEPC_IDX_PROG_CTL, ctl);
    bus(1'b1, `EEPC_IDX_ARRAY_BASE + {1'b0, o}, v);
    bus(1'b1, `EEPC_IDX_PROG_CTL, ctl | 8'h01);
  endtask

  function automatic logic [9:0] roff(input int r);
    return 10'(rs[r] + $urandom_range(rn[r] - 1));
  endfunction

  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    test_mode = 1'b0; boot_mode = 1'b0; array_enable = 1'b1;
    mismatches = 0; num_checks = 0;
    void'($urandom(32'h6ff2193f));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rdchk(`EEPC_IDX_BLOCK_PROT, `EEPC_BP_RESET);
    rdchk(`EEPC_IDX_PROG_CTL, 8'h00);
    rdchk(`EEPC_IDX_OPTIONS, `EEPC_OPT_RESET);
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h00);
    rdchk(`EEPC_IDX_BLOCK_PROT, 8'h00);
    bus(1'b1, `EEPC_IDX_OPTIONS, 8'h01);
    repeat (70) @(posedge clk_sys);
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h61);
    rdchk(`EEPC_IDX_BLOCK_PROT, 8'h61);
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h00);
    rdchk(`EEPC_IDX_BLOCK_PROT, 8'h61);
    bus(1'b1, `EEPC_IDX_OPTIONS, 8'h46);
    rdchk(`EEPC_IDX_OPTIONS, 8'h41);
    rdchk(`EEPC_IDX_PROG_CTL, 8'h00);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'he0);
    rdchk(`EEPC_IDX_PROG_CTL, 8'h00);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h03);
    rdchk(`EEPC_IDX_PROG_CTL, 8'h00);
    cmp_out(5'b00000);
    $display("test registers done");
    test_mode <= 1'b1;
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'hc0);
    rdchk(`EEPC_IDX_PROG_CTL, 8'hc0);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    test_mode <= 1'b0;
    boot_mode <= 1'b1;
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h00);
    rdchk(`EEPC_IDX_BLOCK_PROT, 8'h00);
    bus(1'b1, `EEPC_IDX_OPTIONS, 8'h40);
    @(negedge clk_sys);
    cmp_reg({15'h0, pump}, 16'h1);
    bus(1'b1, `EEPC_IDX_OPTIONS, 8'h00);
    @(negedge clk_sys);
    cmp_reg({15'h0, pump}, 16'h0);
    $display("test modes done");
    for (int i = 0; i < 6; i++) begin
      off = (i == 0) ? 10'd0 : (i == 1) ? 10'd639 : 10'($urandom_range(639));
      rdchk(`EEPC_IDX_ARRAY_BASE + {1'b0, off}, off[7:0] ^ 8'h5a);
    end
    rdchk(`EEPC_IDX_ARRAY_BASE + 11'h280, 8'h00);
    array_enable <= 1'b0;
    rdchk(`EEPC_IDX_ARRAY_BASE + 11'h005, 8'h00);
    array_enable <= 1'b1;
    $display("test reads done");
    off = 10'($urandom_range(639));
    d = 8'($urandom);
    load(8'h16, off, 8'hff);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h02);
    cmp_out(5'b10000);
    rdchk(`EEPC_IDX_ARRAY_BASE + {1'b0, off}, 8'h00);
    bus(1'b1, `EEPC_IDX_ARRAY_BASE + {1'b0, off}, d);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h03);
    cmp_out(5'b10001);
    bus(1'b1, `EEPC_IDX_ARRAY_BASE + {1'b0, off ^ 10'h001}, ~d);
    cmp_reg({6'h0, pa}, {6'h0, off});
    cmp_reg({8'h0, pd}, {8'h0, d});
    repeat (100) @(posedge clk_sys);
    cmp_out(5'b10001);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    cmp_out(5'b00000);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h02);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h03);
    cmp_out(5'b10000);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    foreach (ers[i]) begin
      load(ers[i], 10'($urandom_range(639)), 8'($urandom));
      cmp_out({2'b11, ers[i][4], ers[i][3], 1'b1});
      bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    end
    $display("test program done");
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h80);
    foreach (ers[i]) begin
      load(ers[i], 10'($urandom_range(639)), 8'h00);
      cmp_out({2'b11, ers[i][4], ers[i][3], ers[i][4]});
      bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    end
    for (int r = 0; r < 5; r++) begin
      bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'(1 << r));
      load(8'h02, roff(r), 8'($urandom));
      cmp_out(5'b10000);
      bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'(1 << ((r + 1) % 5)));
      cmp_out(5'b10001);
      bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    end
    bus(1'b1, `EEPC_IDX_BLOCK_PROT, 8'h1f);
    load(8'h06, roff(3), 8'h00);
    cmp_out(5'b11001);
    bus(1'b1, `EEPC_IDX_PROG_CTL, 8'h00);
    $display("test protect done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule
